// >>> hw/matrix_ctrl_pkg.sv
package matrix_ctrl_pkg;

    // ****************************************************
    // Register map (printed offsets are word indexes)
    // ****************************************************
    localparam logic [7:0] IDX_CONFIG = 8'h00;
    localparam logic [7:0] IDX_PULLUP = 8'h0F;
    localparam logic [7:0] IDX_PULLDOWN = 8'h10;
    localparam logic [7:0] IDX_STATUS = 8'h11;
    localparam int ADDR_W = 8;
    localparam int IDX_LSB = 2;

    // ****************************************************
    // Fields and reset values
    // ****************************************************
    localparam int SOFT_SHUTDOWN_BIT = 0;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [7:0] PULLUP_RST = 8'h00;
    localparam logic [7:0] PULLDOWN_RST = 8'h00;

    // ****************************************************
    // Matrix geometry and scan timing
    // ****************************************************
    localparam int NUM_COLS = 12;
    localparam int NUM_ROWS = 8;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCAN_SLOT_NS = 160;
    localparam int SCAN_SLOT_CYC = (SCAN_SLOT_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam logic [7:0] SLOT_LAST = 8'(SCAN_SLOT_CYC - 1);
    localparam logic [3:0] COL_LAST = 4'(NUM_COLS - 1);

    // ****************************************************
    // Bus responses
    // ****************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Function registers held by software
    typedef struct packed {
        logic [7:0] config_val;
        logic [7:0] pullup_sel;
        logic [7:0] pulldown_sel;
    } fn_regs_t;

    // Live state shown in the status register
    typedef struct packed {
        logic host_if_reset;
        logic blanked;
        logic soft_shutdown;
        logic hard_shutdown;
    } status_t;

    typedef enum logic [1:0] {WR_IDLE, WR_COMMIT, WR_RESP} wr_state_t;
    typedef enum logic {RD_IDLE, RD_RESP} rd_state_t;

endpackage

// >>> hw/matrix_shutdown_ctrl.sv
`timescale 1ns/100ps
module matrix_shutdown_ctrl
    import matrix_ctrl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic shutdown_pin_n,
    input wire logic host_if_reset_pin,
    input wire logic [ADDR_W-1:0] s_awaddr,
    input wire logic [2:0] s_awprot,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [ADDR_W-1:0] s_araddr,
    input wire logic [2:0] s_arprot,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    output logic analog_en,
    output logic [NUM_ROWS-1:0] row_current_outputs,
    output logic [NUM_COLS-1:0] column_switch_outputs,
    output logic [NUM_COLS-1:0] column_pullup_en,
    output logic [NUM_ROWS-1:0] row_pulldown_en,
    output logic [7:0] column_pullup_select,
    output logic [7:0] row_pulldown_select
);

    // ****************************************************
    // State
    // ****************************************************
    fn_regs_t regs_reg;
    fn_regs_t regs_next;
    wr_state_t wr_state_reg;
    wr_state_t wr_state_next;
    rd_state_t rd_state_reg;
    rd_state_t rd_state_next;
    logic aw_held_reg;
    logic aw_held_next;
    logic w_held_reg;
    logic w_held_next;
    logic [ADDR_W-1:0] waddr_reg;
    logic [ADDR_W-1:0] waddr_next;
    logic [7:0] wbyte_reg;
    logic [7:0] wbyte_next;
    logic wen_reg;
    logic wen_next;
    logic awready_reg;
    logic wready_reg;
    logic arready_reg;
    logic bvalid_reg;
    logic rvalid_reg;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;
    logic [3:0] col_reg;
    logic [3:0] col_next;
    logic [7:0] slot_reg;
    logic [7:0] slot_next;
    logic analog_reg;
    logic [NUM_ROWS-1:0] rows_reg;
    logic [NUM_COLS-1:0] cols_reg;
    logic [NUM_COLS-1:0] cols_next;
    logic [NUM_COLS-1:0] pullup_reg;
    logic [NUM_ROWS-1:0] pulldown_reg;
    status_t status;

    // ****************************************************
    // Mode decode
    // ****************************************************
    // Pin inputs are synchronous; reset pin holds the bus engine idle
    wire if_rst = host_if_reset_pin;
    wire hard_sd = ~shutdown_pin_n;
    wire soft_sd = ~regs_reg.config_val[SOFT_SHUTDOWN_BIT];
    wire blank = hard_sd | soft_sd;

    assign status.host_if_reset = if_rst;
    assign status.blanked = blank;
    assign status.soft_shutdown = soft_sd;
    assign status.hard_shutdown = hard_sd;

    // ****************************************************
    // Write channel
    // ****************************************************
    // Address and data are taken in either order, then committed
    wire aw_take = s_awvalid & awready_reg;
    wire w_take = s_wvalid & wready_reg;
    wire [ADDR_W-1:0] widx = waddr_reg >> IDX_LSB;
    wire w_hit_cfg = (widx == IDX_CONFIG);
    wire w_hit_pu = (widx == IDX_PULLUP);
    wire w_hit_pd = (widx == IDX_PULLDOWN);
    wire w_hit_st = (widx == IDX_STATUS);
    wire w_mapped = w_hit_cfg | w_hit_pu | w_hit_pd | w_hit_st;
    wire commit = (wr_state_reg == WR_COMMIT);

    always_comb begin
        wr_state_next = wr_state_reg;
        aw_held_next = aw_held_reg | aw_take;
        w_held_next = w_held_reg | w_take;
        waddr_next = aw_take ? s_awaddr : waddr_reg;
        wbyte_next = w_take ? s_wdata[7:0] : wbyte_reg;
        wen_next = w_take ? s_wstrb[0] : wen_reg;
        bresp_next = bresp_reg;
        case (wr_state_reg)
            WR_IDLE: begin
                if (aw_held_next && w_held_next) begin
                    wr_state_next = WR_COMMIT;
                end
            end
            WR_COMMIT: begin
                bresp_next = w_mapped ? RESP_OKAY : RESP_DECERR;
                aw_held_next = 1'b0;
                w_held_next = 1'b0;
                wr_state_next = WR_RESP;
            end
            WR_RESP: begin
                if (s_bready) begin
                    wr_state_next = WR_IDLE;
                end
            end
            default: begin
                wr_state_next = WR_IDLE;
            end
        endcase
        if (if_rst) begin
            wr_state_next = WR_IDLE;
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
        end
    end

    // Register file: only bus writes change it, never shutdown
    always_comb begin
        regs_next = regs_reg;
        if (commit && wen_reg && !if_rst) begin
            if (w_hit_cfg) begin
                regs_next.config_val = wbyte_reg;
            end
            if (w_hit_pu) begin
                regs_next.pullup_sel = wbyte_reg;
            end
            if (w_hit_pd) begin
                regs_next.pulldown_sel = wbyte_reg;
            end
        end
    end

    // ****************************************************
    // Read channel
    // ****************************************************
    wire ar_take = s_arvalid & arready_reg;
    wire [ADDR_W-1:0] ridx = s_araddr >> IDX_LSB;
    wire r_hit_cfg = (ridx == IDX_CONFIG);
    wire r_hit_pu = (ridx == IDX_PULLUP);
    wire r_hit_pd = (ridx == IDX_PULLDOWN);
    wire r_hit_st = (ridx == IDX_STATUS);
    wire r_mapped = r_hit_cfg | r_hit_pu | r_hit_pd | r_hit_st;
    wire [7:0] r_byte = r_hit_cfg ? regs_reg.config_val :
        r_hit_pu ? regs_reg.pullup_sel :
        r_hit_pd ? regs_reg.pulldown_sel :
        r_hit_st ? {4'h0, status} : 8'h00;

    always_comb begin
        rd_state_next = rd_state_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        case (rd_state_reg)
            RD_IDLE: begin
                if (ar_take) begin
                    rdata_next = {24'h000000, r_byte};
                    rresp_next = r_mapped ? RESP_OKAY : RESP_DECERR;
                    rd_state_next = RD_RESP;
                end
            end
            RD_RESP: begin
                if (s_rready) begin
                    rd_state_next = RD_IDLE;
                end
            end
            default: begin
                rd_state_next = RD_IDLE;
            end
        endcase
        if (if_rst) begin
            rd_state_next = RD_IDLE;
        end
    end

    // ****************************************************
    // Matrix scan and blanking
    // ****************************************************
    // Scan restarts from column 0 whenever the matrix is blanked
    wire slot_end = (slot_reg == SLOT_LAST);
    assign slot_next = (blank || slot_end) ? 8'h00 : slot_reg + 8'h01;
    assign col_next = blank ? 4'h0 :
        !slot_end ? col_reg :
        (col_reg == COL_LAST) ? 4'h0 : col_reg + 4'h1;

    // One column switch on per slot, none while blanked
    genvar gc;
    generate
        for (gc = 0; gc < NUM_COLS; gc++) begin : g_col
            assign cols_next[gc] = !blank && (col_next == 4'(gc));
        end
    endgenerate

    // ****************************************************
    // Registers
    // ****************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            regs_reg <= '{CONFIG_RST, PULLUP_RST, PULLDOWN_RST};
            wr_state_reg <= WR_IDLE;
            rd_state_reg <= RD_IDLE;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            waddr_reg <= '0;
            wbyte_reg <= 8'h00;
            wen_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h00000000;
            rresp_reg <= RESP_OKAY;
        end else begin
            regs_reg <= regs_next;
            wr_state_reg <= wr_state_next;
            rd_state_reg <= rd_state_next;
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            waddr_reg <= waddr_next;
            wbyte_reg <= wbyte_next;
            wen_reg <= wen_next;
            bresp_reg <= bresp_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // Ready and valid flags are registered copies of the next state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            arready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            rvalid_reg <= 1'b0;
        end else begin
            bvalid_reg <= (wr_state_next == WR_RESP);
            rvalid_reg <= (rd_state_next == RD_RESP);
            awready_reg <= (wr_state_next == WR_IDLE) && !aw_held_next
                && !if_rst;
            wready_reg <= (wr_state_next == WR_IDLE) && !w_held_next
                && !if_rst;
            arready_reg <= (rd_state_next == RD_IDLE) && !if_rst;
        end
    end

    // Analog enable, drivers and pull resistors
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slot_reg <= 8'h00;
            col_reg <= 4'h0;
            analog_reg <= 1'b0;
            rows_reg <= '0;
            cols_reg <= '0;
            pullup_reg <= '0;
            pulldown_reg <= '0;
        end else begin
            slot_reg <= slot_next;
            col_reg <= col_next;
            analog_reg <= !hard_sd;
            rows_reg <= {NUM_ROWS{!blank}};
            cols_reg <= cols_next;
            pullup_reg <= ~cols_next & {NUM_COLS{!hard_sd}};
            pulldown_reg <= {NUM_ROWS{blank && !hard_sd}};
        end
    end

    // ****************************************************
    // Outputs
    // ****************************************************
    assign s_awready = awready_reg;
    assign s_wready = wready_reg;
    assign s_bvalid = bvalid_reg;
    assign s_bresp = bresp_reg;
    assign s_arready = arready_reg;
    assign s_rvalid = rvalid_reg;
    assign s_rdata = rdata_reg;
    assign s_rresp = rresp_reg;
    assign analog_en = analog_reg;
    assign row_current_outputs = rows_reg;
    assign column_switch_outputs = cols_reg;
    assign column_pullup_en = pullup_reg;
    assign row_pulldown_en = pulldown_reg;
    assign column_pullup_select = regs_reg.pullup_sel;
    assign row_pulldown_select = regs_reg.pulldown_sel;

endmodule

// >>> verif/shutdown_ctrl_assertions.sv
`timescale 1ns/100ps
module shutdown_ctrl_chk
    import matrix_ctrl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic shutdown_pin_n,
    input wire logic host_if_reset_pin,
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic s_bvalid,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    input wire logic analog_en,
    input wire logic [NUM_ROWS-1:0] row_current_outputs,
    input wire logic [NUM_COLS-1:0] column_switch_outputs,
    input wire logic [NUM_COLS-1:0] column_pullup_en,
    input wire logic [NUM_ROWS-1:0] row_pulldown_en,
    input wire logic [7:0] column_pullup_select,
    input wire logic [7:0] row_pulldown_select
);
    // ****************************************************
    // Port relations of the shutdown controller
    // ****************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Address and data taken together by the slave
    sequence s_wr_taken;
        s_awvalid && s_awready && s_wvalid && s_wready;
    endsequence
    // Every row source and column switch off
    sequence s_dark;
        row_current_outputs == '0 && column_switch_outputs == '0;
    endsequence
    property p_analog_off;
        !shutdown_pin_n |=> !analog_en;
    endproperty
    a_analog_off: assert property (p_analog_off) else $error("analog on");
    property p_analog_on;
        aresetn && shutdown_pin_n |=> analog_en;
    endproperty
    a_analog_on: assert property (p_analog_on) else $error("analog off");
    property p_hw_dark;
        !shutdown_pin_n |=> s_dark ##0 (column_pullup_en | row_pulldown_en) == 0;
    endproperty
    a_hw_dark: assert property (p_hw_dark) else $error("lit in shutdown");
    property p_pull_off;
        (row_pulldown_en & row_current_outputs) == 0
            && (column_pullup_en & column_switch_outputs) == 0;
    endproperty
    a_pull_off: assert property (p_pull_off) else $error("pull on live");
    property p_keep;
        !s_bvalid && !$past(s_bvalid) |->
            $stable(column_pullup_select) && $stable(row_pulldown_select);
    endproperty
    a_keep: assert property (p_keep) else $error("select drifted");
    property p_host_rst;
        host_if_reset_pin [*3] |-> !(s_awready || s_wready || s_arready);
    endproperty
    a_host_rst: assert property (p_host_rst) else $error("bus not held");
    property p_wr_ans;
        s_wr_taken |-> ##[1:3] s_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("no write reply");
    property p_rd_ans;
        s_arvalid && s_arready |=> s_rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("no read reply");
endmodule
bind matrix_shutdown_ctrl shutdown_ctrl_chk chk_u (.*);

// >>> verif/host_model.sv
`timescale 1ns/100ps
module host_model (
    input wire logic aclk,
    output logic [7:0] s_awaddr,
    output logic s_awvalid,
    input wire logic s_awready,
    output logic [31:0] s_wdata,
    output logic s_wvalid,
    input wire logic s_wready,
    input wire logic s_bvalid,
    output logic s_bready,
    output logic [7:0] s_araddr,
    output logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    output logic s_rready
);
    // ****************************************************
    // Host bus master, one write and one read at a time
    // ****************************************************
    initial begin
        s_awaddr = 8'h00;
        s_awvalid = 1'b0;
        s_wdata = 32'h0;
        s_wvalid = 1'b0;
        s_bready = 1'b0;
        s_araddr = 8'h00;
        s_arvalid = 1'b0;
        s_rready = 1'b0;
    end
    // Offer both channels, drop each once taken, wait for the reply
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_awready)
                s_awvalid <= 1'b0;
            if (s_wready)
                s_wvalid <= 1'b0;
        end while (!s_bvalid);
        s_bready <= 1'b0;
    endtask
    // Read data is taken by the caller at the reply edge
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_arready)
                s_arvalid <= 1'b0;
        end while (!s_rvalid);
        s_rready <= 1'b0;
    endtask
endmodule

// >>> verif/matrix_driver_shutdown_reset_ctrl_tb.sv
`timescale 1ns/100ps
module matrix_driver_shutdown_reset_ctrl_tb
    import matrix_ctrl_pkg::*;
;
    logic aclk, aresetn, shutdown_pin_n, host_if_reset_pin, analog_en;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    logic [ADDR_W-1:0] s_awaddr, s_araddr;
    logic [2:0] s_awprot, s_arprot;
    logic [3:0] s_wstrb;
    logic [31:0] s_wdata, s_rdata;
    logic [1:0] s_bresp, s_rresp;
    logic [NUM_ROWS-1:0] row_current_outputs, row_pulldown_en;
    logic [NUM_COLS-1:0] column_switch_outputs, column_pullup_en;
    logic [7:0] column_pullup_select, row_pulldown_select;
    int fails = 0;
    int n_compared = 0;
    localparam logic [7:0] A_CFG = IDX_CONFIG << IDX_LSB;
    localparam logic [7:0] A_PU = IDX_PULLUP << IDX_LSB;
    localparam logic [7:0] A_PD = IDX_PULLDOWN << IDX_LSB;
    localparam logic [7:0] A_ST = IDX_STATUS << IDX_LSB;
    // ****************************************************
    // Harness, shared checks and bus helpers
    // ****************************************************
    matrix_shutdown_ctrl dut_u (.*);
    host_model host_u (.*);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Cuts a hang short
    initial begin
        repeat (5000) @(posedge aclk);
        fails++;
        conclude();
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.wr(a, {24'h0, d});
        chk(s_bresp, RESP_OKAY);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a);
        chk(s_rdata, {24'h0, e});
        chk(s_rresp, RESP_OKAY);
    endtask
    // Soft shutdown blanks the matrix, pulls follow off outputs
    task automatic t_soft();
        rchk(A_CFG, 8'h00);
        chk(row_current_outputs, 8'h00);
        wr(A_CFG, 8'h01);
        tick(1);
        chk(row_current_outputs, 8'hFF);
        chk($onehot(column_switch_outputs), 1'b1);
        chk(column_pullup_en ^ column_switch_outputs, 12'hFFF);
        chk(row_pulldown_en, 8'h00);
        wr(A_CFG, 8'h00);
        tick(1);
        chk({row_current_outputs, column_switch_outputs}, 20'h0);
        chk(row_pulldown_en, 8'hFF);
        rchk(A_ST, 8'h06);
        rchk(A_CFG, 8'h00);
        wr(A_CFG, 8'h01);
    endtask
    // Resistor selects come from their own registers
    task automatic t_pulls();
        wr(A_PU, 8'hA5);
        wr(A_PD, 8'h5A);
        tick(1);
        chk(column_pullup_select, 8'hA5);
        chk(row_pulldown_select, 8'h5A);
        rchk(A_PU, 8'hA5);
        s_wstrb <= 4'h0;
        wr(A_PU, 8'h3C);
        s_wstrb <= 4'hF;
        rchk(A_PU, 8'hA5);
    endtask
    // Pin shutdown darkens all, registers stay reachable and kept
    task automatic t_hw();
        @(posedge aclk);
        shutdown_pin_n <= 1'b0;
        tick(2);
        chk(analog_en, 1'b0);
        chk({row_current_outputs, row_pulldown_en}, 16'h0);
        chk(column_pullup_en, 12'h0);
        wr(A_PD, 8'hC3);
        rchk(A_PD, 8'hC3);
        rchk(A_PU, 8'hA5);
        rchk(A_ST, 8'h05);
        @(posedge aclk);
        shutdown_pin_n <= 1'b1;
        tick(2);
        chk(analog_en, 1'b1);
        chk(row_current_outputs, 8'hFF);
        chk(row_pulldown_select, 8'hC3);
    endtask
    // Host interface reset holds the bus, then an unmapped read
    task automatic t_host_rst();
        @(posedge aclk);
        host_if_reset_pin <= 1'b1;
        tick(3);
        chk({s_awready, s_wready, s_arready}, 3'h0);
        @(posedge aclk);
        host_if_reset_pin <= 1'b0;
        rchk(A_PD, 8'hC3);
        host_u.rd(8'h48);
        chk(s_rresp, RESP_DECERR);
        chk(s_rdata, 32'h0);
    endtask
    initial begin
        aresetn = 1'b0;
        shutdown_pin_n = 1'b1;
        host_if_reset_pin = 1'b0;
        s_awprot = 3'h0;
        s_arprot = 3'h0;
        s_wstrb = 4'hF;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        tick(2);
        t_soft();
        t_pulls();
        t_hw();
        t_host_rst();
        conclude();
    end
endmodule
